// >>> rtl/pmic_irq_and_sequence_regs.sv
`timescale 1ns/1ps
// How it works
// [RL1] each buck low-output event (66% of target) sets its status1 bit 6..3
// [RL2] deglitched short button press sets status1 bit 2
// [RL3] deglitched long button press sets status1 bit 1
// [RL4] supply below power-off threshold sets status1 bit 0
// [RL5] button forced shutdown sets status2 bit 7; enable2 bit 7 resets to 1
// [RL6] button rising edge sets status2 bit 6; enable2 bit 6 resets to 0
// [RL7] button falling edge sets status2 bit 5; enable2 bit 5 resets to 0
// [RL8] 125 degree warning sets status2 bit 1
// [RL9] 100 degree warning sets status2 bit 0
// [RL10] priority code 0 is off, 1 first on, up to 12 last on
// [RL11] power-down order is the reverse of power-up order
// [RL12] sequence register one bits 7..4 hold buck two priority
// [RL13] sequence register one bits 3..0 hold buck one priority
// [RL14] enable1 gates status1; top five reset to 1, low three to 0
// [RL15] interrupt is registered: high one cycle after any enabled status bit is set, low one cycle after none is
// [RL16] sequence register two holds buck four high, buck three low
// [RL17] reserved status and enable bits read zero, ignore writes
module pmic_irq_and_sequence_regs #(
    parameter int LONG_PRESS_CYC = pmic_pkg::LONG_PRESS_DEF_CYC
) (
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic power_button_in,
    input wire logic overtemp_in,
    input wire logic [3:0] buck_low_in,
    input wire logic supply_low_in,
    input wire logic temp_warn_high_in,
    input wire logic temp_warn_low_in,
    input wire logic button_shutdown_in,
    output logic irq_out,
    output logic [3:0] buck_power_on_out,
    output logic [3:0][3:0] buck_on_slot_out,
    output logic [3:0][3:0] buck_off_slot_out
);
    import pmic_pkg::*;

    localparam logic [24:0] LONG_LAST = 25'(LONG_PRESS_CYC - 1);
    localparam logic [24:0] LONG_CNT = 25'(LONG_PRESS_CYC);

    logic [1:0] rst_pipe_q;
    logic rst_n;
    logic [7:0] en1_q, en2_q, st1_q, st2_q, seq1_q, seq2_q;
    logic [7:0] ev1, ev2, clr1, clr2;
    logic btn_filt_q, btn_prev_q, irq_q;
    logic [9:0] glitch_cnt_q;
    logic [24:0] hold_cnt_q;
    logic rise_ev, fall_ev, short_ev, long_ev;
    logic [15:0] prios;
    reg_if rif();

    function automatic logic [3:0] on_slot(input logic [3:0] code);
        on_slot = (code > SEQ_LAST) ? SEQ_LAST : code;
    endfunction

    function automatic logic [3:0] off_slot(input logic [3:0] code);
        off_slot = (code == SEQ_OFF) ? SEQ_OFF : 4'(SEQ_LAST + 4'h1 - on_slot(code));
    endfunction

    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_pipe_q <= 2'b00;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_q[1];

    serial_target u_target (
        .clk_in(clk_sys_in),
        .rst_n_in(rst_n),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_oe_out(sda_oe_out),
        .rif(rif.bus)
    );
    // open-drain: the pin is only ever pulled low
    assign sda_out = 1'b0;

    // [RL2] [RL3] 32 us button deglitch
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            btn_filt_q <= 1'b0;
            glitch_cnt_q <= 10'h000;
        end else if (power_button_in == btn_filt_q) begin
            glitch_cnt_q <= 10'h000;
        end else if (glitch_cnt_q == DEGLITCH_LAST) begin
            btn_filt_q <= power_button_in;
            glitch_cnt_q <= 10'h000;
        end else begin
            glitch_cnt_q <= glitch_cnt_q + 10'h001;
        end
    end

    // press duration, saturates at the long-press count
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            btn_prev_q <= 1'b0;
            hold_cnt_q <= 25'h0000000;
        end else begin
            btn_prev_q <= btn_filt_q;
            if (!btn_filt_q) begin
                hold_cnt_q <= 25'h0000000;
            end else if (hold_cnt_q != LONG_CNT) begin
                hold_cnt_q <= hold_cnt_q + 25'h0000001;
            end
        end
    end

    // [RL6] [RL7] filtered button edges
    assign rise_ev = btn_filt_q && !btn_prev_q;
    assign fall_ev = !btn_filt_q && btn_prev_q;
    // [RL2] [RL3] short on release, long once held long enough
    assign short_ev = fall_ev && (hold_cnt_q != LONG_CNT);
    assign long_ev = btn_filt_q && (hold_cnt_q == LONG_LAST);

    // [RL1] [RL4] status1 event map
    assign ev1 = {overtemp_in, buck_low_in[0], buck_low_in[1], buck_low_in[2], buck_low_in[3],
                  short_ev, long_ev, supply_low_in};
    // [RL5] [RL8] [RL9] status2 event map
    assign ev2 = {button_shutdown_in, rise_ev, fall_ev, 3'b000, temp_warn_high_in, temp_warn_low_in};
    assign clr1 = (rif.rd_stb && rif.addr == ADDR_ST1) ? 8'hff : 8'h00;
    assign clr2 = (rif.rd_stb && rif.addr == ADDR_ST2) ? 8'hff : 8'h00;

    // sticky status, cleared by reading, a new event wins over the clear
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            st1_q <= 8'h00;
            st2_q <= 8'h00;
        end else begin
            st1_q <= (st1_q & ~clr1) | ev1;
            // [RL17] reserved status bits held at zero
            st2_q <= ((st2_q & ~clr2) | ev2) & ST2_MASK;
        end
    end

    // [RL14] [RL5] enables and sequence fields
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            en1_q <= EN1_RST;
            en2_q <= EN2_RST;
            seq1_q <= SEQ1_RST;
            seq2_q <= SEQ2_RST;
        end else if (rif.wr_stb) begin
            case (rif.addr)
                ADDR_EN1: en1_q <= rif.wdata;
                // [RL17] reserved enable bits ignore writes
                ADDR_EN2: en2_q <= rif.wdata & EN2_MASK;
                ADDR_SEQ1: seq1_q <= rif.wdata;
                ADDR_SEQ2: seq2_q <= rif.wdata;
                default: ;
            endcase
        end
    end

    always_comb begin
        case (rif.addr)
            ADDR_EN1: rif.rdata = en1_q;
            ADDR_ST1: rif.rdata = st1_q;
            ADDR_EN2: rif.rdata = en2_q;
            ADDR_ST2: rif.rdata = st2_q;
            ADDR_SEQ1: rif.rdata = seq1_q;
            ADDR_SEQ2: rif.rdata = seq2_q;
            default: rif.rdata = 8'h00;
        endcase
    end

    // [RL15] interrupt request
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |((st1_q & en1_q) | (st2_q & en2_q));
        end
    end
    assign irq_out = irq_q;

    // [RL12] [RL13] [RL16] buck fields, buck one lowest
    assign prios = {seq2_q, seq1_q};

    for (genvar i = 0; i < 4; i++) begin : g_buck
        // [RL10] [RL11] on slot and mirrored off slot
        always_ff @(posedge clk_sys_in or negedge rst_n) begin
            if (!rst_n) begin
                buck_power_on_out[i] <= 1'b0;
                buck_on_slot_out[i] <= 4'h0;
                buck_off_slot_out[i] <= 4'h0;
            end else begin
                buck_power_on_out[i] <= prios[4*i +: 4] != SEQ_OFF;
                buck_on_slot_out[i] <= on_slot(prios[4*i +: 4]);
                buck_off_slot_out[i] <= off_slot(prios[4*i +: 4]);
            end
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n);

    sequence s_enabled_pending;
        |((st1_q & en1_q) | (st2_q & en2_q));
    endsequence
    sequence s_short_release;
        $fell(btn_filt_q) && (hold_cnt_q != LONG_CNT);
    endsequence

    a_buck_low_set: assert property (buck_low_in[0] |=> st1_q[ST1_BUCK_FIRST]) // [RL1]
        else $error("buck one low not flagged");
    a_short_press: assert property (s_short_release |=> st1_q[ST1_SHORT]) // [RL2]
        else $error("short press not flagged");
    a_deglitch_time: assert property ($changed(btn_filt_q) |-> $past(glitch_cnt_q) == DEGLITCH_LAST) // [RL3]
        else $error("button changed before deglitch time");
    a_long_press: assert property (long_ev |=> st1_q[ST1_LONG] && hold_cnt_q == LONG_CNT) // [RL3]
        else $error("long press not flagged");
    a_supply_low: assert property (supply_low_in |=> st1_q[ST1_SUPPLY]) // [RL4]
        else $error("supply low lost on clear");
    a_rise_flag: assert property ($rose(btn_filt_q) |=> st2_q[ST2_RISE] ##1 !btn_prev_q == 1'b0) // [RL6]
        else $error("rising edge not flagged");
    a_fall_flag: assert property ($fell(btn_filt_q) |=> st2_q[ST2_FALL]) // [RL7]
        else $error("falling edge not flagged");
    a_temp_warn: assert property (temp_warn_high_in && temp_warn_low_in |=> st2_q[ST2_TWH] && st2_q[ST2_TWL]) // [RL8]
        else $error("temperature warning not flagged");
    a_shdn_reset: assert property ($rose(rst_pipe_q[1]) |-> en2_q == EN2_RST && en1_q == EN1_RST) // [RL14]
        else $error("enable reset values wrong");
    a_irq_follow: assert property (s_enabled_pending ##1 s_enabled_pending |-> irq_q) // [RL15]
        else $error("interrupt missing while enabled status set");
    a_irq_quiet: assert property (!irq_q |-> $past(st1_q & en1_q) == 8'h00 && $past(st2_q & en2_q) == 8'h00) // [RL15]
        else $error("interrupt dropped while enabled status set");
    a_reserved_zero: assert property (en2_q[4:0] == 5'h00 && st2_q[4:2] == 3'h0) // [RL17]
        else $error("reserved bits not zero");
    a_seq_reverse: assert property (buck_power_on_out[3] |-> 5'(buck_on_slot_out[3]) + 5'(buck_off_slot_out[3]) == 5'(SEQ_LAST) + 5'h01) // [RL11]
        else $error("off order not reverse of on order");
    a_seq_write: assert property (rif.wr_stb && rif.addr == ADDR_SEQ1 |=> seq1_q == $past(rif.wdata) ##1 buck_on_slot_out[1] == on_slot(seq1_q[7:4])) // [RL12]
        else $error("sequence field not written");
endmodule

// >>> rtl/pmic_pkg.sv
package pmic_pkg;
    // clock and timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int DEGLITCH_NS = 32000;
    localparam int DEGLITCH_CYC = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0] DEGLITCH_LAST = 10'(DEGLITCH_CYC - 1);
    localparam int LONG_PRESS_MS = 1000;
    localparam int LONG_PRESS_DEF_CYC = LONG_PRESS_MS * (1000000 / CLK_PERIOD_NS);
    // serial target address, value is arbitrary
    localparam logic [6:0] DEV_ADDR = 7'h2a;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    // register offsets
    localparam logic [7:0] ADDR_EN1 = 8'h28;
    localparam logic [7:0] ADDR_ST1 = 8'h29;
    localparam logic [7:0] ADDR_EN2 = 8'h2a;
    localparam logic [7:0] ADDR_ST2 = 8'h2b;
    localparam logic [7:0] ADDR_SEQ1 = 8'h2c;
    localparam logic [7:0] ADDR_SEQ2 = 8'h2d;
    // field positions
    localparam int ST1_OT = 7;
    localparam int ST1_BUCK_FIRST = 6;
    localparam int ST1_SHORT = 2;
    localparam int ST1_LONG = 1;
    localparam int ST1_SUPPLY = 0;
    localparam int ST2_SHDN = 7;
    localparam int ST2_RISE = 6;
    localparam int ST2_FALL = 5;
    localparam int ST2_TWH = 1;
    localparam int ST2_TWL = 0;
    localparam logic [7:0] EN2_MASK = 8'he0;
    localparam logic [7:0] ST2_MASK = 8'he3;
    // reset values
    localparam logic [7:0] EN1_RST = 8'hf8;
    localparam logic [7:0] EN2_RST = 8'h80;
    localparam logic [7:0] SEQ1_RST = 8'h21;
    localparam logic [7:0] SEQ2_RST = 8'h43;
    // priority codes
    localparam logic [3:0] SEQ_OFF = 4'h0;
    localparam logic [3:0] SEQ_LAST = 4'hc;
    typedef enum logic [3:0] {
        BUS_IDLE = 4'h0,
        BUS_ADDR = 4'h1,
        BUS_ACK_ADDR = 4'h3,
        BUS_REG = 4'h2,
        BUS_ACK_REG = 4'h6,
        BUS_WDATA = 4'h7,
        BUS_ACK_W = 4'h5,
        BUS_RDATA = 4'h4,
        BUS_RACK = 4'hc
    } bus_state_t;
endpackage

// >>> rtl/reg_if.sv
`timescale 1ns/1ps
interface reg_if;
    logic wr_stb;
    logic rd_stb;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport bus(output wr_stb, output rd_stb, output addr, output wdata, input rdata);
    modport regs(input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface

// >>> rtl/serial_target.sv
`timescale 1ns/1ps
module serial_target (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_oe_out,
    reg_if.bus rif
);
    import pmic_pkg::*;

    bus_state_t st_q;
    logic scl_q, sda_q, rw_q, oe_q, wr_q, rd_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q, ptr_q;
    logic scl_rise, scl_fall, start_c, stop_c;

    assign scl_rise = scl_in && !scl_q;
    assign scl_fall = !scl_in && scl_q;
    assign start_c = scl_in && scl_q && sda_q && !sda_in;
    assign stop_c = scl_in && scl_q && !sda_q && sda_in;
    assign sda_oe_out = oe_q;
    assign rif.wr_stb = wr_q;
    assign rif.rd_stb = rd_q;
    assign rif.addr = ptr_q;
    assign rif.wdata = sh_q;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= BUS_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            oe_q <= 1'b0;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
        end else begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            if (start_c) begin
                st_q <= BUS_ADDR;
                cnt_q <= 4'h0;
                oe_q <= 1'b0;
            end else if (stop_c) begin
                st_q <= BUS_IDLE;
                oe_q <= 1'b0;
            end else if (scl_rise) begin
                if (st_q == BUS_ADDR || st_q == BUS_REG || st_q == BUS_WDATA) begin
                    sh_q <= {sh_q[6:0], sda_in};
                    cnt_q <= cnt_q + 4'h1;
                end else if (st_q == BUS_RDATA) begin
                    cnt_q <= cnt_q + 4'h1;
                end else if (st_q == BUS_RACK) begin
                    // not acknowledged: stop sending until next start
                    if (sda_in) begin
                        st_q <= BUS_IDLE;
                    end else begin
                        ptr_q <= ptr_q + 8'h01;
                    end
                end
            end else if (scl_fall) begin
                case (st_q)
                    BUS_ADDR: if (cnt_q == BYTE_BITS) begin
                        cnt_q <= 4'h0;
                        if (sh_q[7:1] == DEV_ADDR) begin
                            st_q <= BUS_ACK_ADDR;
                            oe_q <= 1'b1;
                            rw_q <= sh_q[0];
                        end else begin
                            st_q <= BUS_IDLE;
                        end
                    end
                    BUS_REG: if (cnt_q == BYTE_BITS) begin
                        cnt_q <= 4'h0;
                        ptr_q <= sh_q;
                        st_q <= BUS_ACK_REG;
                        oe_q <= 1'b1;
                    end
                    BUS_WDATA: if (cnt_q == BYTE_BITS) begin
                        cnt_q <= 4'h0;
                        wr_q <= 1'b1;
                        st_q <= BUS_ACK_W;
                        oe_q <= 1'b1;
                    end
                    BUS_ACK_ADDR, BUS_RACK: if (st_q == BUS_RACK || rw_q) begin
                        st_q <= BUS_RDATA;
                        sh_q <= rif.rdata;
                        oe_q <= ~rif.rdata[7];
                        rd_q <= 1'b1;
                    end else begin
                        st_q <= BUS_REG;
                        oe_q <= 1'b0;
                    end
                    BUS_ACK_REG: begin
                        st_q <= BUS_WDATA;
                        oe_q <= 1'b0;
                    end
                    BUS_ACK_W: begin
                        st_q <= BUS_WDATA;
                        oe_q <= 1'b0;
                        ptr_q <= ptr_q + 8'h01;
                    end
                    BUS_RDATA: if (cnt_q == BYTE_BITS) begin
                        st_q <= BUS_RACK;
                        cnt_q <= 4'h0;
                        oe_q <= 1'b0;
                    end else begin
                        sh_q <= {sh_q[6:0], 1'b0};
                        oe_q <= ~sh_q[6];
                    end
                    default: st_q <= BUS_IDLE;
                endcase
            end
        end
    end
endmodule

// >>> verification/serial_host.sv
`timescale 1ns/1ps
module serial_host (
    input wire logic clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_pull_out
);
    import pmic_pkg::*;
    logic nack_seen = 1'b0;
    initial begin
        scl_out = 1'b1;
        sda_pull_out = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // sda falls while scl high; also works as repeated start
    task automatic start_cond();
        sda_pull_out <= 1'b0;
        tick(4);
        scl_out <= 1'b1;
        tick(4);
        sda_pull_out <= 1'b1;
        tick(4);
        scl_out <= 1'b0;
        tick(4);
    endtask
    task automatic stop_cond();
        sda_pull_out <= 1'b1;
        tick(4);
        scl_out <= 1'b1;
        tick(4);
        sda_pull_out <= 1'b0;
        tick(4);
    endtask
    task automatic bit_out(input logic b);
        sda_pull_out <= ~b;
        tick(4);
        scl_out <= 1'b1;
        tick(4);
        scl_out <= 1'b0;
        tick(4);
    endtask
    // line released, pull-up gives 1 unless the device pulls
    task automatic bit_in(output logic b);
        sda_pull_out <= 1'b0;
        tick(4);
        scl_out <= 1'b1;
        tick(2);
        b = sda_in;
        tick(2);
        scl_out <= 1'b0;
        tick(4);
    endtask
    task automatic send_byte(input logic [7:0] d);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_out(d[i]);
        end
        bit_in(a);
        if (a !== 1'b0) begin
            nack_seen = 1'b1;
        end
    endtask
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        start_cond();
        send_byte({DEV_ADDR, 1'b0});
        send_byte(a);
        send_byte(d);
        stop_cond();
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        start_cond();
        send_byte({DEV_ADDR, 1'b0});
        send_byte(a);
        start_cond();
        send_byte({DEV_ADDR, 1'b1});
        for (int i = 7; i >= 0; i--) begin
            bit_in(d[i]);
        end
        bit_out(1'b1);
        stop_cond();
    endtask
endmodule

// >>> verification/pmic_irq_and_sequence_regs_test.sv
`timescale 1ns/1ps
module pmic_irq_and_sequence_regs_test;
    import pmic_pkg::*;
    localparam int LONG_CYC = 2000;
    logic clk_sys, arst_n, scl, host_pull, dut_oe, dut_sda, sda, button, overtemp, supply_low, twh, twl, shdn, irq;
    logic [3:0] buck_low, power_on;
    logic [3:0][3:0] on_slot, off_slot;
    int n_mismatch = 0;
    int compares = 0;
    assign sda = (dut_oe ? dut_sda : 1'b1) & ~host_pull;
    pmic_irq_and_sequence_regs #(.LONG_PRESS_CYC(LONG_CYC)) DUT (.clk_sys_in(clk_sys), .arst_n_in(arst_n),
        .scl_in(scl), .sda_in(sda), .sda_out(dut_sda), .sda_oe_out(dut_oe), .power_button_in(button),
        .overtemp_in(overtemp), .buck_low_in(buck_low), .supply_low_in(supply_low), .temp_warn_high_in(twh),
        .temp_warn_low_in(twl), .button_shutdown_in(shdn), .irq_out(irq), .buck_power_on_out(power_on),
        .buck_on_slot_out(on_slot), .buck_off_slot_out(off_slot));
    serial_host host (.clk_in(clk_sys), .sda_in(sda), .scl_out(scl), .sda_pull_out(host_pull));
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic run(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.read_reg(a, d);
        check(d, exp);
    endtask
    // one-cycle event: {shdn, twh, twl, supply, overtemp, buck[3:0]}
    task automatic pulse(input logic [8:0] ev);
        {shdn, twh, twl, supply_low, overtemp, buck_low} <= ev;
        run(1);
        {shdn, twh, twl, supply_low, overtemp, buck_low} <= 9'h000;
        run(3);
    endtask
    task automatic press(input int n);
        button <= 1'b1;
        run(n);
        button <= 1'b0;
        run(900);
    endtask
    task automatic chk_slot(input int k, input logic [3:0] c);
        logic [3:0] s;
        s = (c > 4'hc) ? 4'hc : c;
        check(on_slot[k], s);
        check(off_slot[k], (s == 4'h0) ? 4'h0 : 4'hd - s);
        check(power_on[k], c != 4'h0);
    endtask
    task automatic t_reset();
        rd(ADDR_EN1, 8'hf8); // enable reset
        rd(ADDR_EN2, 8'h80); // enable reset
        rd(ADDR_ST1, 8'h00); // idle status
        rd(ADDR_ST2, 8'h00); // idle status
        check(irq, 1'b0); // idle interrupt
        $display("test reset done");
    endtask
    task automatic t_seq();
        logic [3:0] c, e;
        for (int i = 0; i < 16; i++) begin
            c = 4'(i);
            e = 4'(15 - i);
            host.write_reg(ADDR_SEQ1, {e, c});
            host.write_reg(ADDR_SEQ2, {c, e});
            rd(ADDR_SEQ1, {e, c}); // field readback
            rd(ADDR_SEQ2, {c, e}); // field readback
            chk_slot(0, c); // buck one order
            chk_slot(1, e); // buck two order
            chk_slot(2, e); // buck three order
            chk_slot(3, c); // buck four order
        end
        $display("test sequence done");
    endtask
    task automatic t_status1();
        pulse(9'h020);
        check(irq, 1'b0); // disabled event
        rd(ADDR_ST1, 8'h01); // supply low
        pulse(9'h019);
        check(irq, 1'b1); // enabled event
        rd(ADDR_ST1, 8'hc8); // buck one and four
        run(2);
        check(irq, 1'b0); // cleared status
        rd(ADDR_ST1, 8'h00); // cleared by read
        host.write_reg(ADDR_EN1, 8'h01);
        pulse(9'h026);
        check(irq, 1'b1); // supply enabled
        rd(ADDR_ST1, 8'h31); // buck two and three
        host.write_reg(ADDR_EN1, 8'h00);
        pulse(9'h010);
        check(irq, 1'b0); // masked overtemp
        rd(ADDR_ST1, 8'h80); // masked event still latched
        $display("test status one done");
    endtask
    task automatic t_status2();
        pulse(9'h1c0);
        check(irq, 1'b1); // shutdown enabled
        rd(ADDR_ST2, 8'h83); // event bits
        host.write_reg(ADDR_EN2, 8'hff);
        rd(ADDR_EN2, 8'he0); // reserved enable bits
        host.write_reg(ADDR_ST2, 8'hff);
        rd(ADDR_ST2, 8'h00); // read-only status
        host.write_reg(ADDR_ST1, 8'hff);
        rd(ADDR_ST1, 8'h00); // read-only status
        rd(8'h40, 8'h00); // unmapped reads zero
        host.write_reg(ADDR_EN2, 8'h00);
        pulse(9'h100);
        check(irq, 1'b0); // masked shutdown
        rd(ADDR_ST2, 8'h80); // shutdown bit
        $display("test status two done");
    endtask
    task automatic t_button();
        press(100);
        rd(ADDR_ST1, 8'h00); // glitch filtered
        rd(ADDR_ST2, 8'h00); // glitch filtered
        host.write_reg(ADDR_EN2, 8'h40);
        press(1200);
        check(irq, 1'b1); // rise enabled
        rd(ADDR_ST1, 8'h04); // short press
        rd(ADDR_ST2, 8'h60); // both edges
        press(3500);
        rd(ADDR_ST1, 8'h02); // long press
        rd(ADDR_ST2, 8'h60); // both edges
        $display("test button done");
    endtask
    initial begin
        // clean reset edge before the first clock, so no flop starts unknown
        arst_n = 1'b1;
        {button, shdn, twh, twl, supply_low, overtemp, buck_low} = 10'h000;
        #1;
        arst_n = 1'b0;
        run(8);
        arst_n <= 1'b1;
        run(5);
        t_reset();
        t_seq();
        t_status1();
        t_status2();
        t_button();
        check(host.nack_seen, 1'b0); // every byte sent by the host acknowledged
        test_done();
    end
    initial begin
        run(80000);
        n_mismatch++;
        test_done();
    end
endmodule
